// ### dram_chip_select_decode_map.sv
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Bit 0 of each base word enables its window; disabled windows never hit.
// - Address bits whose mask bit is one are left out of the compare.
// - High mask bits grow a window; mask bit for address 25 gives 64 MB.
// - Low mask bits 15:9 drop low address bits in the interleaved layout.
// - Bank map holds four 4-bit pair size codes, 0 is 32 MB to 6 is 2 GB.
// - Spare bits 1:0 pick monitored reader: 00 texture0, x1 render1, 10 render0.
// - Monitor counts when counter selectors hold event codes 7E and 7F.
// - Spare bits 5:2 are XORed into render client 1 address bits 16:13.
// - Hash is one to one: spare bit 2 to address 13, upward in order.
// - Bank map bit 31 picks interface width, 0 is 64 and 1 is 128 bits.
// - High base field supplies address bits above the 32 MB granule.
// - Low base field counts only in interleave mode, otherwise left out of the compare.
module dram_chip_select_decode_map (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  input  wire logic        req_valid,
  input  wire logic [39:0] req_addr,
  output logic             hit_valid,
  output logic             hit,
  output logic      [2:0]  hit_window,
  output logic      [3:0]  hit_size,
  input  wire logic        render1_valid,
  input  wire logic [39:0] render1_addr,
  output logic             render1_hashed_valid,
  output logic      [39:0] render1_hashed_addr,
  input  wire logic [2:0]  rd_issue,
  input  wire logic [2:0]  rd_return,
  output logic             wide_interface,
  output logic             newer_decode
);
  localparam int NW = dram_map_pkg::NUM_WINDOWS;
  localparam int NR = dram_map_pkg::NUM_REGS;
  localparam int CW = dram_map_pkg::COUNT_W;

  logic [31:0]             regs_r [NR];
  logic [7:0]              perf_ctrl_r;
  logic [7:0]              perf_ctrl1_r;
  logic                    perf_clear;
  dram_map_pkg::bus_state_t state_r;
  logic [7:0]              dph_idx_r;
  logic                    dph_ok_r;
  logic                    hreadyout_r;
  logic [31:0]             hrdata_r;
  logic                    take;
  logic [31:0]             bank_map;
  logic [NW-1:0]           win_hit;
  logic                    any_hit;
  logic [2:0]              first_hit;
  logic                    hit_valid_r;
  logic                    hit_r;
  logic [2:0]              hit_window_r;
  logic [3:0]              hit_size_r;
  logic                    hashed_valid_r;
  logic [39:0]             hashed_addr_r;
  logic [39:0]             hashed_addr;
  logic                    mon_issue;
  logic                    mon_done;
  logic [CW-1:0]           lat_sum;
  logic [CW-1:0]           lat_count;
  logic [31:0]             read_value;

  // Slot of a word index inside the map, or NR when it is not a map register.
  function automatic int unsigned slot_of(input logic [7:0] idx);
    int unsigned s;
    s = NR;
    for (int i = 0; i < NR; i++) begin
      if (dram_map_pkg::REG_INDEX[i] == idx) begin
        s = i;
      end
    end
    return s;
  endfunction

  // Bits of a slot that software may change; the rest read back as stored.
  function automatic logic [31:0] wmask_of(input int unsigned s);
    logic [31:0] m;
    if (s < NW) begin
      m = dram_map_pkg::BASE_WMASK;
    end else if (s < dram_map_pkg::SLOT_MASK0 + 4) begin
      m = dram_map_pkg::MASK_WMASK;
    end else if (s < dram_map_pkg::SLOT_BANK_MAP) begin
      m = dram_map_pkg::MASKN_WMASK;
    end else begin
      m = dram_map_pkg::BANK_WMASK;
    end
    return m;
  endfunction

  assign bank_map = regs_r[dram_map_pkg::SLOT_BANK_MAP];
  assign take     = hsel && hready && htrans[1];

  // Bus handshake. Writes finish with no wait state; reads take one wait state
  // so read data leaves a flop and already sees a write that ended just before.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r   <= dram_map_pkg::BUS_IDLE;
      dph_idx_r <= 8'h00;
      dph_ok_r  <= 1'b0;
    end else if (take) begin
      state_r   <= hwrite ? dram_map_pkg::BUS_WRITE : dram_map_pkg::BUS_READ_WAIT;
      dph_idx_r <= haddr[9:2];
      dph_ok_r  <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00) &&
                   (hsize == 3'b010);
    end else begin
      case (state_r)
        dram_map_pkg::BUS_READ_WAIT: state_r <= dram_map_pkg::BUS_READ_DONE;
        dram_map_pkg::BUS_READ_DONE: state_r <= dram_map_pkg::BUS_IDLE;
        dram_map_pkg::BUS_WRITE:     state_r <= dram_map_pkg::BUS_IDLE;
        default:                     state_r <= dram_map_pkg::BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hreadyout_r <= 1'b1;
    end else if (take && !hwrite) begin
      hreadyout_r <= 1'b0;
    end else if (state_r == dram_map_pkg::BUS_READ_WAIT) begin
      hreadyout_r <= 1'b1;
    end
  end

  always_comb begin
    int unsigned s;
    s = slot_of(dph_idx_r);
    read_value = 32'h0000_0000;
    if (!dph_ok_r) begin
      read_value = 32'h0000_0000;
    end else if (s < NR) begin
      read_value = regs_r[s];
    end else if (dph_idx_r == dram_map_pkg::IDX_PERF_CTRL) begin
      read_value = {16'h0000, perf_ctrl1_r, perf_ctrl_r};
    end else if (dph_idx_r == dram_map_pkg::IDX_COUNT0) begin
      read_value = lat_sum[31:0];
    end else if (dph_idx_r == dram_map_pkg::IDX_COUNT1) begin
      read_value = lat_count[31:0];
    end else if (dph_idx_r == dram_map_pkg::IDX_COUNT_HIGH) begin
      read_value = {lat_count[CW-1:32], lat_sum[CW-1:32]};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata_r <= 32'h0000_0000;
    end else if (state_r == dram_map_pkg::BUS_READ_WAIT) begin
      hrdata_r <= read_value;
    end
  end

  // Map registers; a write touches only the bits the field layout defines.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NR; i++) begin
        regs_r[i] <= dram_map_pkg::REG_RESET[i];
      end
    end else if (state_r == dram_map_pkg::BUS_WRITE && dph_ok_r) begin
      for (int i = 0; i < NR; i++) begin
        if (slot_of(dph_idx_r) == i) begin
          regs_r[i] <= (regs_r[i] & ~wmask_of(i)) | (hwdata & wmask_of(i));
        end
      end
    end
  end

  // Writing the counter control word also restarts both counters from zero on the
  // same edge that stores it, so a request issued right after the write is counted.
  assign perf_clear = (state_r == dram_map_pkg::BUS_WRITE) && dph_ok_r &&
                      (dph_idx_r == dram_map_pkg::IDX_PERF_CTRL);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      perf_ctrl_r  <= 8'(dram_map_pkg::PERF_CTRL_RESET);
      perf_ctrl1_r <= 8'(dram_map_pkg::PERF_CTRL_RESET);
    end else if (perf_clear) begin
      perf_ctrl_r  <= hwdata[7:0];
      perf_ctrl1_r <= hwdata[15:8];
    end
  end

  // Window decode.
  for (genvar w = 0; w < NW; w++) begin : g_win
    window_match u_match (
      .base    (regs_r[w]),
      .mask    (regs_r[dram_map_pkg::SLOT_MASK0 + w]),
      .addr    (req_addr),
      .use_low (bank_map[dram_map_pkg::DECODE_BIT]),
      .use_ext (bank_map[dram_map_pkg::LAYOUT_BIT]),
      .hit     (win_hit[w])
    );
  end

  always_comb begin
    any_hit   = 1'b0;
    first_hit = 3'h0;
    for (int w = NW - 1; w >= 0; w--) begin
      if (win_hit[w]) begin
        any_hit   = 1'b1;
        first_hit = 3'(w);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hit_valid_r  <= 1'b0;
      hit_r        <= 1'b0;
      hit_window_r <= 3'h0;
      hit_size_r   <= 4'h0;
    end else begin
      hit_valid_r <= req_valid;
      if (req_valid) begin
        hit_r        <= any_hit;
        hit_window_r <= first_hit;
        hit_size_r   <= bank_map[first_hit[2:1] * dram_map_pkg::SIZE_CODE_W +:
                                 dram_map_pkg::SIZE_CODE_W];
      end
    end
  end

  // Bank hash on the second render client's reads and writes.
  always_comb begin
    hashed_addr = render1_addr;
    for (int b = 0; b < dram_map_pkg::HASH_W; b++) begin
      hashed_addr[dram_map_pkg::HASH_ADDR_LSB + b] =
        render1_addr[dram_map_pkg::HASH_ADDR_LSB + b] ^
        bank_map[dram_map_pkg::HASH_LSB + b];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hashed_valid_r <= 1'b0;
      hashed_addr_r  <= 40'h00_0000_0000;
    end else begin
      hashed_valid_r <= render1_valid;
      if (render1_valid) begin
        hashed_addr_r <= hashed_addr;
      end
    end
  end

  // Latency monitor client select.
  always_comb begin
    if (bank_map[dram_map_pkg::MON_SEL_LSB]) begin
      mon_issue = rd_issue[dram_map_pkg::CLIENT_RENDER1];
      mon_done  = rd_return[dram_map_pkg::CLIENT_RENDER1];
    end else if (bank_map[dram_map_pkg::MON_SEL_LSB + 1]) begin
      mon_issue = rd_issue[dram_map_pkg::CLIENT_RENDER0];
      mon_done  = rd_return[dram_map_pkg::CLIENT_RENDER0];
    end else begin
      mon_issue = rd_issue[dram_map_pkg::CLIENT_TEX0];
      mon_done  = rd_return[dram_map_pkg::CLIENT_TEX0];
    end
  end

  latency_monitor #(
    .CNT_W (CW),
    .OUT_W (8)
  ) u_monitor (
    .clk      (clk),
    .rst      (rst),
    .clear    (perf_clear),
    .issue    (mon_issue),
    .done     (mon_done),
    .en_sum   (perf_ctrl_r == dram_map_pkg::EVENT_LAT_SUM),
    .en_count (perf_ctrl1_r == dram_map_pkg::EVENT_LAT_COUNT),
    .sum_r    (lat_sum),
    .count_r  (lat_count)
  );

  assign hreadyout            = hreadyout_r;
  assign hrdata               = hrdata_r;
  assign hresp                = 1'b0;
  assign hit_valid            = hit_valid_r;
  assign hit                  = hit_r;
  assign hit_window           = hit_window_r;
  assign hit_size             = hit_size_r;
  assign render1_hashed_valid = hashed_valid_r;
  assign render1_hashed_addr  = hashed_addr_r;
  assign wide_interface       = bank_map[dram_map_pkg::WIDTH_BIT];
  assign newer_decode         = bank_map[dram_map_pkg::DECODE_BIT];
endmodule
`default_nettype wire

// ### dram_map_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module dram_map_monitor (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic        hreadyout,
  input  wire logic        req_valid,
  input  wire logic        hit_valid,
  input  wire logic        hit,
  input  wire logic [2:0]  hit_window,
  input  wire logic [3:0]  hit_size,
  input  wire logic        render1_valid,
  input  wire logic [39:0] render1_addr,
  input  wire logic        render1_hashed_valid,
  input  wire logic [39:0] render1_hashed_addr,
  input  wire logic        wide_interface,
  input  wire logic        newer_decode
);
  logic       wr_ph;
  logic [7:0] wr_idx;
  logic [7:0] en_sh;
  logic [7:0] en_d;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Window enables are shadowed from bus writes, because only the ports are visible here.
  // The delayed copy matches what a request taken one edge earlier could see.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ph  <= 1'b0;
      wr_idx <= 8'h00;
      en_sh  <= 8'h0F;
      en_d   <= 8'h0F;
    end else begin
      wr_ph  <= hsel & hready & htrans[1] & hwrite & (haddr[31:10] == 22'h0) & (haddr[1:0] == 2'h0);
      wr_idx <= haddr[9:2] - 8'h63;
      en_d   <= en_sh;
      if (wr_ph && hready && wr_idx < 8'h08) begin
        en_sh[wr_idx[2:0]] <= hwdata[0];
      end
    end
  end

  AST_HIT_VALID_ON: assert property (req_valid |=> hit_valid)
    else $error("Decode request gave no result one cycle later");
  AST_HIT_VALID_OFF: assert property (!req_valid |=> !hit_valid)
    else $error("Decode result appeared without a request");
  AST_ENABLED_ONLY: assert property (hit_valid && hit |-> en_d[hit_window])
    else $error("Disabled window reported as a hit");
  AST_MISS_WINDOW: assert property (hit_valid && !hit |-> hit_window == 3'h0)
    else $error("Miss reported with a nonzero window");
  AST_RESULT_HOLD: assert property (!hit_valid |-> $stable({hit, hit_window, hit_size}))
    else $error("Decode result changed without a request");
  AST_HASH_VALID: assert property (render1_valid |=> render1_hashed_valid)
    else $error("Hashed request missing one cycle later");
  AST_HASH_KEEP: assert property (render1_valid |=>
    render1_hashed_addr[39:17] == $past(render1_addr[39:17]) &&
    render1_hashed_addr[12:0] == $past(render1_addr[12:0]))
    else $error("Hash touched address bits outside the bank field");
  AST_CONFIG_HOLD: assert property ($changed({wide_interface, newer_decode}) |-> $past(wr_ph))
    else $error("Width or decode select changed without a bus write");

  CV_HIT4: cover property (hit_valid && hit && hit_window == 3'h4);
  CV_MISS: cover property (hit_valid && !hit);
  CV_HASH: cover property (render1_hashed_valid);
  CV_WAIT: cover property (!hreadyout);
endmodule

bind dram_chip_select_decode_map dram_map_monitor i_dram_map_monitor (
  .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .req_valid(req_valid),
  .hit_valid(hit_valid), .hit(hit), .hit_window(hit_window), .hit_size(hit_size),
  .render1_valid(render1_valid), .render1_addr(render1_addr),
  .render1_hashed_valid(render1_hashed_valid), .render1_hashed_addr(render1_hashed_addr),
  .wide_interface(wide_interface), .newer_decode(newer_decode)
);
`default_nettype wire

// ### dram_map_pkg.sv
package dram_map_pkg;

  localparam int NUM_WINDOWS = 8;
  localparam int NUM_REGS    = 17;

  // Word indices of the map registers; the byte address is four times the index.
  localparam logic [7:0] REG_INDEX [NUM_REGS] = '{
    8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h68, 8'h69, 8'h6A,
    8'h6B, 8'h6C, 8'h6D, 8'h6E, 8'h6F, 8'h70, 8'h71, 8'h72, 8'h73};
  localparam int SLOT_MASK0    = 8;
  localparam int SLOT_BANK_MAP = 16;

  localparam logic [7:0] IDX_PERF_CTRL  = 8'h80;
  localparam logic [7:0] IDX_COUNT0     = 8'h81;
  localparam logic [7:0] IDX_COUNT1     = 8'h82;
  localparam logic [7:0] IDX_COUNT_HIGH = 8'h83;

  localparam logic [31:0] REG_RESET [NUM_REGS] = '{
    32'h0000_0001, 32'h0400_0001, 32'h0800_0001, 32'h0C00_0001,
    32'h1000_0000, 32'h1000_0000, 32'h1000_0000, 32'h1000_0000,
    32'h03F8_FFE0, 32'h03F8_FFE0, 32'h03F8_FFE0, 32'h03F8_FFE0,
    32'h3FE0_FE00, 32'h3FE0_FE00, 32'h3FE0_FE00, 32'h3FE0_FE00,
    32'h4000_0055};
  localparam logic [31:0] BASE_WMASK  = 32'hFFF8_FFE1;
  localparam logic [31:0] MASK_WMASK  = 32'h3FF8_FFE0;
  localparam logic [31:0] MASKN_WMASK = 32'h3FE0_FE00;
  localparam logic [31:0] BANK_WMASK  = 32'hDFFF_FFFF;

  // Field layout of base and mask words.
  localparam int          ENABLE_BIT      = 0;
  localparam logic [31:0] HIGH_FIELD_BITS = 32'hFFE0_0000;
  localparam logic [31:0] LOW_FIELD_BITS  = 32'h0000_FE00;
  localparam logic [31:0] EXT_FIELD_BITS  = 32'h0018_01E0;
  localparam int          REG_TO_ADDR     = 4;

  // Field layout of the bank map word.
  localparam int SIZE_CODE_W   = 4;
  localparam int MON_SEL_LSB   = 16;
  localparam int HASH_LSB      = 18;
  localparam int HASH_W        = 4;
  localparam int HASH_ADDR_LSB = 13;
  localparam int LAYOUT_BIT    = 28;
  localparam int DECODE_BIT    = 30;
  localparam int WIDTH_BIT     = 31;

  localparam logic [7:0] EVENT_LAT_SUM   = 8'h7E;
  localparam logic [7:0] EVENT_LAT_COUNT = 8'h7F;
  localparam int         PERF_CTRL_RESET = 0;
  localparam int         COUNT_W         = 48;

  localparam int CLIENT_TEX0    = 0;
  localparam int CLIENT_RENDER0 = 1;
  localparam int CLIENT_RENDER1 = 2;

  typedef enum logic [1:0] {
    BUS_IDLE      = 2'b00,
    BUS_WRITE     = 2'b01,
    BUS_READ_WAIT = 2'b10,
    BUS_READ_DONE = 2'b11
  } bus_state_t;

endpackage

// ### gfx_client_model.sv
`timescale 1ns/10ps
`default_nettype none
module gfx_client_model (
  input  wire logic        clk,
  output logic      [2:0]  rd_issue,
  output logic      [2:0]  rd_return,
  output logic             render1_valid,
  output logic      [39:0] render1_addr
);
  initial begin
    rd_issue      = 3'h0;
    rd_return     = 3'h0;
    render1_valid = 1'b0;
    render1_addr  = 40'h0;
  end

  // All three readers issue together and each returns after its own latency, so a wrong
  // client choice shows up as a wrong latency sum. The last latency must be the largest.
  task automatic reads(input int l0, input int l1, input int l2);
    int n;
    rd_issue <= 3'b111;
    for (n = 1; n <= l2; n++) begin
      @(posedge clk);
      rd_issue  <= 3'b000;
      rd_return <= {n == l2, n == l1, n == l0};
    end
    @(posedge clk);
    rd_return <= 3'b000;
  endtask

  // An idle address bus shows the inverse of the last request, never a stale copy.
  task automatic render(input logic [39:0] a);
    render1_valid <= 1'b1;
    render1_addr  <= a;
    @(posedge clk);
    render1_valid <= 1'b0;
    render1_addr  <= ~a;
  endtask
endmodule
`default_nettype wire

// ### latency_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module latency_monitor #(
  parameter int CNT_W = dram_map_pkg::COUNT_W,
  parameter int OUT_W = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             clear,
  input  wire logic             issue,
  input  wire logic             done,
  input  wire logic             en_sum,
  input  wire logic             en_count,
  output logic      [CNT_W-1:0] sum_r,
  output logic      [CNT_W-1:0] count_r
);
  logic [OUT_W-1:0] open_r;

  // Requests still in flight; each accrues one memory clock of latency per cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      open_r <= '0;
    end else if (clear) begin
      open_r <= '0;
    end else if (issue && !done) begin
      open_r <= open_r + 1'b1;
    end else if (done && !issue && open_r != '0) begin
      open_r <= open_r - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sum_r <= '0;
    end else if (clear) begin
      sum_r <= '0;
    end else if (en_sum) begin
      sum_r <= sum_r + CNT_W'(open_r);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_r <= '0;
    end else if (clear) begin
      count_r <= '0;
    end else if (en_count && done) begin
      count_r <= count_r + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### tb_dram_chip_select_decode_map.sv
`timescale 1ns/10ps
`default_nettype none
module tb_dram_chip_select_decode_map;
  logic        clk, rst, hsel, hwrite, hreadyout, hresp, req_valid, hit_valid, hit;
  logic        render1_valid, render1_hashed_valid, wide_interface, newer_decode;
  logic [1:0]  htrans;
  logic [2:0]  hsize, hit_window, rd_issue, rd_return;
  logic [3:0]  hit_size;
  logic [31:0] haddr, hwdata, hrdata, c0, c1;
  logic [39:0] req_addr, render1_addr, render1_hashed_addr;
  int          fail_count = 0;
  int          checks = 0;
  int          cyc = 0;
  int          i;
  logic [7:0]  acc_idx [4] = '{8'h67, 8'h6B, 8'h70, 8'h73};
  logic [31:0] acc_mask [4] = '{dram_map_pkg::BASE_WMASK, dram_map_pkg::MASK_WMASK,
                               dram_map_pkg::MASKN_WMASK, dram_map_pkg::BANK_WMASK};
  int          lat_of_sel [4] = '{3, 7, 5, 7};

  dram_chip_select_decode_map i_dram_chip_select_decode_map (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .req_valid(req_valid), .req_addr(req_addr),
    .hit_valid(hit_valid), .hit(hit), .hit_window(hit_window), .hit_size(hit_size),
    .render1_valid(render1_valid), .render1_addr(render1_addr),
    .render1_hashed_valid(render1_hashed_valid), .render1_hashed_addr(render1_hashed_addr),
    .rd_issue(rd_issue), .rd_return(rd_return), .wide_interface(wide_interface),
    .newer_decode(newer_decode));

  gfx_client_model i_gfx_client_model (
    .clk(clk), .rd_issue(rd_issue), .rd_return(rd_return),
    .render1_valid(render1_valid), .render1_addr(render1_addr));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      $display("Error at %0t: run did not finish in time", $time);
      summarize();
    end
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({39'h0, hresp}, 40'h0);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, {22'h0, idx, 2'b00}, d, rd);
  endtask

  task automatic rdv(input logic [7:0] idx, output logic [31:0] d);
    bus(1'b0, {22'h0, idx, 2'b00}, 32'h0, d);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    rdv(idx, d);
    chk({8'h0, d}, {8'h0, exp});
  endtask

  task automatic resets();
    int k;
    for (k = 0; k < dram_map_pkg::NUM_REGS; k++) begin
      rdc(dram_map_pkg::REG_INDEX[k], dram_map_pkg::REG_RESET[k]);
    end
  endtask

  task automatic flags(input logic [1:0] exp);
    #1;
    chk({38'h0, wide_interface, newer_decode}, {38'h0, exp});
    @(posedge clk);
  endtask

  task automatic dec(input logic [39:0] a, input logic h, input logic [2:0] w,
                     input logic [3:0] s);
    req_valid <= 1'b1;
    req_addr  <= a;
    @(posedge clk);
    req_valid <= 1'b0;
    req_addr  <= ~a;
    #1;
    chk({31'h0, hit_valid, hit, hit_window, h ? hit_size : 4'h0},
        {31'h0, 1'b1, h, w, h ? s : 4'h0});
    @(posedge clk);
  endtask

  task automatic hash(input logic [3:0] p, input logic [39:0] a);
    wr(8'h73, 32'h4000_0055 | ({28'h0, p} << 18));
    i_gfx_client_model.render(a);
    #1;
    chk(render1_hashed_addr, a ^ ({36'h0, p} << 13));
    chk({39'h0, render1_hashed_valid}, 40'h1);
    @(posedge clk);
  endtask

  initial begin
    rst = 1'b1;
    hsize = 3'h2;
    {hsel, htrans, hwrite, haddr, hwdata, req_valid, req_addr} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    resets();
    for (i = 0; i < 4; i++) begin
      wr(acc_idx[i], 32'hFFFF_FFFF);
      rdc(acc_idx[i], acc_mask[i]);
      wr(acc_idx[i], 32'h0);
      rdc(acc_idx[i], 32'h0);
    end
    wr(8'h73, 32'hFFFF_FFFF);
    flags(2'b11);
    wr(8'h73, 32'h0);
    flags(2'b00);
    bus(1'b1, 32'h0000_1000, 32'hFFFF_FFFF, c0);
    bus(1'b0, 32'h0000_1000, 32'h0, c0);
    chk({8'h0, c0}, 40'h0);
    rdc(8'h74, 32'h0);
    // A second reset in mid-run must bring every map register back to its default.
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    resets();
    dec(40'h00_0000_0000, 1'b1, 3'h0, 4'h5);
    dec(40'h00_4000_0000, 1'b1, 3'h1, 4'h5);
    dec(40'h00_C000_0000, 1'b1, 3'h3, 4'h5);
    dec(40'h01_0000_0000, 1'b0, 3'h0, 4'h0);
    wr(8'h67, 32'h1000_0001);
    dec(40'h01_0000_0000, 1'b1, 3'h4, 4'h0);
    wr(8'h6F, 32'h0);
    dec(40'h01_0200_0000, 1'b0, 3'h0, 4'h0);
    wr(8'h6F, 32'h0020_0000);
    dec(40'h01_0200_0000, 1'b1, 3'h4, 4'h0);
    dec(40'h01_0400_0000, 1'b0, 3'h0, 4'h0);
    wr(8'h67, 32'h1000_0201);
    wr(8'h6F, 32'h0);
    dec(40'h01_0000_2000, 1'b1, 3'h4, 4'h0);
    dec(40'h01_0000_0000, 1'b0, 3'h0, 4'h0);
    wr(8'h6F, 32'h0000_0200);
    dec(40'h01_0000_0000, 1'b1, 3'h4, 4'h0);
    wr(8'h6F, 32'h0);
    wr(8'h73, 32'h0000_0055);
    dec(40'h01_0000_0000, 1'b1, 3'h4, 4'h0);
    wr(8'h73, 32'h4000_3621);
    dec(40'h01_0000_2000, 1'b1, 3'h4, 4'h6);
    wr(8'h64, 32'h0000_0001);
    dec(40'h00_0000_0000, 1'b1, 3'h0, 4'h1);
    wr(8'h63, 32'h0);
    dec(40'h00_0000_0000, 1'b1, 3'h1, 4'h1);
    hash(4'h5, 40'hAB_CDEF_1234);
    hash(4'hA, 40'h12_3456_7FFF);
    for (i = 0; i < 4; i++) begin
      wr(8'h73, 32'h4000_0055 | {14'h0, i[1:0], 16'h0});
      wr(8'h80, 32'h0000_7F7E);
      i_gfx_client_model.reads(3, 5, 7);
      rdv(8'h81, c0);
      rdv(8'h82, c1);
      chk({8'h0, c0}, 40'(lat_of_sel[i]));
      chk({8'h0, c1}, 40'h1);
      chk({8'h0, c0 / c1}, 40'(lat_of_sel[i]));
    end
    wr(8'h80, 32'h0);
    i_gfx_client_model.reads(3, 5, 7);
    rdc(8'h81, 32'h0);
    rdc(8'h83, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire

// ### window_match.sv
`timescale 1ns/10ps
`default_nettype none
module window_match (
  input  wire logic [31:0] base,
  input  wire logic [31:0] mask,
  input  wire logic [39:0] addr,
  input  wire logic        use_low,
  input  wire logic        use_ext,
  output logic             hit
);
  logic [31:0] addr_view;
  logic [31:0] care;

  always_comb begin
    // Register bit k lines up with address bit k+4, so the word is addr[35:9].
    addr_view = {addr[35:dram_map_pkg::REG_TO_ADDR + 5], 5'h00};
    care = dram_map_pkg::HIGH_FIELD_BITS;
    if (use_low) begin
      care = care | dram_map_pkg::LOW_FIELD_BITS;
    end
    if (use_ext) begin
      care = care | dram_map_pkg::EXT_FIELD_BITS;
    end
    care = care & ~mask;
    hit = base[dram_map_pkg::ENABLE_BIT] &
          ((addr_view & care) == (base & care));
  end
endmodule
`default_nettype wire
